/* File: include/cbt_defines.svh */
// constants for the can bit timing configuration block
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH

// register addresses and reset values
`define CBT_ADDR_W        16
`define CBT_ADDR_LOW      16'hffb9
`define CBT_ADDR_HIGH     16'hffba
`define CBT_RST_LOW       8'h18
`define CBT_RST_HIGH      8'h0e

// bit_timing_low fields
`define CBT_LEN_MSB       4
`define CBT_LEN_LSB       0
`define CBT_SPLO_MSB      7
`define CBT_SPLO_LSB      5

// bit_timing_high fields
`define CBT_FINE_BIT      7
`define CBT_FRAME_START_CLEAR_CTL_BIT      6
`define CBT_TRIPLE_SAMPLING_BIT      5
`define CBT_LISTEN_BIT    4
`define CBT_SJW_MSB       3
`define CBT_SJW_LSB       2
`define CBT_SPHI_MSB      1
`define CBT_SPHI_LSB      0

// legal code ranges of the timing fields
`define CBT_LEN_MIN       5'h07
`define CBT_LEN_MAX       5'h18
`define CBT_SP_MIN        5'h01
`define CBT_SP_MAX        5'h10

// widths and small constants
`define CBT_RATIO_W       9
`define CBT_POS_W         5
`define CBT_ONE_POS       5'h01
`define CBT_ONE_RATIO     9'h001
`define CBT_ZERO_BYTE     8'h00

`endif

/* File: include/cbt_pkg.sv */
// types shared by the bit timing configuration modules
`include "cbt_defines.svh"

package cbt_pkg;

  // prescaler state: quantum counter and its pulse
  typedef struct packed {
    logic [`CBT_RATIO_W-1:0] cnt;
    logic                    tq;
  } cbt_tq_state_t;

  // whole state of the bit timing block
  typedef struct packed {
    logic [7:0]              low;
    logic [7:0]              high;
    logic [7:0]              rd_data;
    logic                    s1;
    logic                    s2;
    logic                    s3;
    logic                    rx_stable;
    logic [1:0]              hist;
    logic                    edge_pend;
    logic                    resync_done;
    logic [`CBT_POS_W-1:0]   pos;
    logic [`CBT_POS_W-1:0]   cur_sp;
    logic [`CBT_POS_W-1:0]   cur_end;
    logic                    sample;
    logic                    bit_start;
    logic                    rx_bit;
    logic [`CBT_POS_W-1:0]   bit_len;
    logic [`CBT_POS_W-1:0]   sample_pos;
    logic [`CBT_POS_W-1:0]   seg2;
    logic [2:0]              jump_width_field;
    logic [`CBT_RATIO_W-1:0] ratio;
    logic                    cfg_bad;
  } cbt_state_t;

endpackage

/* File: logic/cbt_tq_gen.sv */
// time quantum generator: one pulse per prescaler ratio of core clocks
`timescale 1ns/1ns
`default_nettype none

module cbt_tq_gen
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  // divide ratio, 1 and up
  input  wire logic [`CBT_RATIO_W-1:0] ratio_i,
  // quantum pulse
  output logic                         tq_o
);

  cbt_tq_state_t st_reg;   // registered state
  cbt_tq_state_t st_next;  // next state

  // count core clocks, pulse on the last one of each group
  always_comb
  begin
    st_next = st_reg;
    st_next.tq = 1'b0;
    // >= also recovers at once when the ratio shrinks mid count
    if (st_reg.cnt >= ratio_i - `CBT_ONE_RATIO)
    begin
      st_next.cnt = '0;
      st_next.tq  = 1'b1; // RULE3
    end
    else
    begin
      st_next.cnt = st_reg.cnt + `CBT_ONE_RATIO;
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tq_o = st_reg.tq;

endmodule // cbt_tq_gen

`default_nettype wire

/* File: logic/cbt_bit_timing.sv */
// can bit timing configuration: registers, prescaler and bit timer
//
// Contract
// RULE1: coarse mode ratio is twice field plus two
// RULE2: fine mode ratio is eight-bit field plus one
// RULE3: one quantum per ratio of core clocks
// RULE4: coarse mode ignores the two upper prescaler bits
// RULE5: software keeps phase segment two at least 3
// RULE6: phase segment two is length minus sample position
// RULE7: reset loads 18h low and 0eh high
// RULE8: bit length is field plus one quanta
// RULE9: sample point is split field plus one quanta
// RULE10: jump width is field plus one quanta
// RULE11: high register bit order fixed from bit seven
// RULE12: both registers read and written as bytes
// RULE13: software writes only in initialization mode
// RULE14: triple sampling takes majority of three samples
// RULE15: fine ratio follows the table, field plus one
`timescale 1ns/1ns
`default_nettype none

module cbt_bit_timing
  import cbt_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  // byte register access
  input  wire logic [`CBT_ADDR_W-1:0]  addr_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  input  wire logic [7:0]              wr_data_i,
  output logic      [7:0]              rd_data_o,
  // prescaler field from outside registers
  input  wire logic [5:0]              prescaler_field_i,
  input  wire logic [1:0]              prescaler_upper_i,
  // can receive pin
  input  wire logic                    can_rx_i,
  // timing events
  output logic                         time_quantum_o,
  output logic                         bit_start_o,
  output logic                         sample_o,
  output logic                         rx_bit_o,
  // decoded configuration
  output logic      [`CBT_RATIO_W-1:0] prescale_ratio_o,
  output logic      [`CBT_POS_W-1:0]   bit_len_o,
  output logic      [`CBT_POS_W-1:0]   sample_pos_o,
  output logic      [`CBT_POS_W-1:0]   phase_segment_two_o,
  output logic      [2:0]              jump_width_o,
  output logic                         cfg_bad_o,
  // mode bits
  output logic                         fine_prescale_mode_o,
  output logic                         frame_start_clear_ctl_o,
  output logic                         triple_sampling_o,
  output logic                         listen_only_o
);

  cbt_state_t st_reg;   // registered state
  cbt_state_t st_next;  // next state
  logic       tq;       // quantum pulse from the prescaler

  // smaller of two quantum counts
  function automatic logic [`CBT_POS_W-1:0] min_pos(
    input logic [`CBT_POS_W-1:0] a,
    input logic [`CBT_POS_W-1:0] b
  );
    min_pos = (a < b) ? a : b;
  endfunction

  // force a code into its legal range so the timer never locks up
  function automatic logic [`CBT_POS_W-1:0] clamp_code(
    input logic [`CBT_POS_W-1:0] code,
    input logic [`CBT_POS_W-1:0] lo,
    input logic [`CBT_POS_W-1:0] hi
  );
    if (code < lo)
      clamp_code = lo;
    else if (code > hi)
      clamp_code = hi;
    else
      clamp_code = code;
  endfunction

  // majority of three samples
  function automatic logic majority(
    input logic a,
    input logic b,
    input logic c
  );
    majority = (a & b) | (a & c) | (b & c);
  endfunction

  // field views of the two registers
  logic [`CBT_POS_W-1:0] len_code;   // raw bit length code
  logic [`CBT_POS_W-1:0] sp_code;    // raw sample point code
  logic [1:0]            sjw_code;   // raw jump width code
  logic                  fine;       // fine prescale mode

  assign len_code = st_reg.low[`CBT_LEN_MSB:`CBT_LEN_LSB]; // RULE8
  assign sp_code  = {st_reg.high[`CBT_SPHI_MSB:`CBT_SPHI_LSB],
                     st_reg.low[`CBT_SPLO_MSB:`CBT_SPLO_LSB]}; // RULE9
  assign sjw_code = st_reg.high[`CBT_SJW_MSB:`CBT_SJW_LSB];
  assign fine     = st_reg.high[`CBT_FINE_BIT];

  // prescaler divides by the registered ratio
  // a ratio change sets the end of the quantum in progress, or ends it at once
  // when the running count is already past the new end
  cbt_tq_gen u_tq_gen (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .ratio_i   (st_reg.ratio),
    .tq_o      (tq)
  );

  // next state: registers, decode, synchroniser and bit timer
  always_comb
  begin
    logic [`CBT_POS_W-1:0] len_q;    // legal length code
    logic [`CBT_POS_W-1:0] sp_q;     // legal sample code
    logic [`CBT_POS_W-1:0] err;      // phase error in quanta
    logic [`CBT_POS_W-1:0] sjw_q;    // jump width in quanta
    logic                  vote;     // sampled bus level
    len_q = clamp_code(len_code, `CBT_LEN_MIN, `CBT_LEN_MAX);
    sp_q  = clamp_code(sp_code, `CBT_SP_MIN, `CBT_SP_MAX);
    sjw_q = {3'h0, sjw_code} + `CBT_ONE_POS;
    err   = '0;
    vote  = 1'b1;
    st_next = st_reg;
    st_next.sample    = 1'b0;
    st_next.bit_start = 1'b0;

    // byte writes; software waits for initialization mode
    // no write lock here: a write in mid frame lands at once and
    // the timer picks it up at the next bit start
    if (wr_i)
    begin
      if (addr_i == `CBT_ADDR_LOW)
        st_next.low = wr_data_i; // RULE12
      else if (addr_i == `CBT_ADDR_HIGH)
        st_next.high = wr_data_i; // RULE11
    end

    // byte reads answered next cycle, unmapped reads as zero
    // a read beside a write in one cycle returns the old byte
    if (rd_i)
    begin
      if (addr_i == `CBT_ADDR_LOW)
        st_next.rd_data = st_reg.low; // RULE12
      else if (addr_i == `CBT_ADDR_HIGH)
        st_next.rd_data = st_reg.high;
      else
        st_next.rd_data = `CBT_ZERO_BYTE;
    end

    // prescaler ratio from the selected resolution
    // the top fine code gives 256, hence the ninth ratio bit
    if (fine)
      st_next.ratio = {1'b0, prescaler_upper_i, prescaler_field_i}
                      + `CBT_ONE_RATIO; // RULE2 RULE15
    else
      // upper bits left out here on purpose
      st_next.ratio = {2'b00, prescaler_field_i, 1'b0}
                      + `CBT_ONE_RATIO + `CBT_ONE_RATIO; // RULE1 RULE4

    // decoded lengths in quanta
    // prohibited codes show here as written; only the timer clamps
    st_next.bit_len    = len_code + `CBT_ONE_POS; // RULE8
    st_next.sample_pos = sp_code + `CBT_ONE_POS; // RULE9
    st_next.seg2       = len_code - sp_code; // RULE6
    st_next.jump_width_field        = {1'b0, sjw_code} + 3'h1; // RULE10
    st_next.cfg_bad    = (len_q != len_code) || (sp_q != sp_code);

    // three stage pin synchroniser, change taken once s2 and s3 agree
    // s1 may go metastable, so only s2 ever reads it
    st_next.s1 = can_rx_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3)
      st_next.rx_stable = st_reg.s3;

    // bit timer runs on quantum pulses
    // pos is the quantum in progress, one being the sync quantum
    if (tq)
    begin
      // keep the two previous quantum samples for the majority vote
      st_next.hist = {st_reg.hist[0], st_reg.rx_stable};

      // sample point closes this quantum
      if (st_reg.pos == st_reg.cur_sp)
      begin
        if (st_reg.high[`CBT_TRIPLE_SAMPLING_BIT])
          vote = majority(st_reg.hist[1], st_reg.hist[0],
                          st_reg.rx_stable); // RULE14
        else
          vote = st_reg.rx_stable; // RULE14
        st_next.rx_bit = vote;
        st_next.sample = 1'b1;
      end

      if (st_reg.edge_pend && st_reg.pos != `CBT_ONE_POS)
      begin
        // edge inside the bit: move sample point or end the bit early
        st_next.edge_pend   = 1'b0;
        st_next.resync_done = 1'b1;
        if (st_reg.pos <= st_reg.cur_sp)
        begin
          // late edge: stretch segment one by at most the jump width
          // the bit end moves too, so segment two keeps its length
          err = min_pos(st_reg.pos - `CBT_ONE_POS, sjw_q); // RULE10
          st_next.cur_sp  = st_reg.cur_sp + err;
          st_next.cur_end = st_reg.cur_end + err;
          st_next.pos     = st_reg.pos + `CBT_ONE_POS;
        end
        else
        begin
          // early edge: cut phase segment two by at most the jump width
          err = st_reg.cur_end - st_reg.pos + `CBT_ONE_POS;
          if (err <= sjw_q)
          begin
            st_next.pos         = `CBT_ONE_POS;
            st_next.cur_sp      = sp_q + `CBT_ONE_POS;
            st_next.cur_end     = len_q + `CBT_ONE_POS;
            st_next.resync_done = 1'b0;
            st_next.bit_start   = 1'b1;
          end
          else
          begin
            st_next.cur_end = st_reg.cur_end - sjw_q;
            st_next.pos     = st_reg.pos + `CBT_ONE_POS;
          end
        end
      end
      else if (st_reg.pos >= st_reg.cur_end)
      begin
        // bit complete: reload timing from the registers
        st_next.pos         = `CBT_ONE_POS;
        st_next.cur_sp      = sp_q + `CBT_ONE_POS; // RULE9
        st_next.cur_end     = len_q + `CBT_ONE_POS; // RULE8
        st_next.edge_pend   = 1'b0;
        st_next.resync_done = 1'b0;
        st_next.bit_start   = 1'b1;
      end
      else
      begin
        // edge in the sync quantum needs no correction
        st_next.edge_pend = 1'b0;
        st_next.pos       = st_reg.pos + `CBT_ONE_POS;
      end
    end

    // recessive to dominant edge arms one resync per bit; it sits
    // after the timer so a fresh edge wins over the clears above,
    // while an edge in the sync quantum is dropped as it needs no fix
    if (st_reg.rx_stable && !st_next.rx_stable &&
        !st_next.resync_done && !(tq && st_reg.pos == `CBT_ONE_POS))
      st_next.edge_pend = 1'b1;
  end

  // state register, reset values of the timing registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg            <= '0;
      st_reg.low        <= `CBT_RST_LOW; // RULE7
      st_reg.high       <= `CBT_RST_HIGH; // RULE7
      st_reg.s1         <= 1'b1;
      st_reg.s2         <= 1'b1;
      st_reg.s3         <= 1'b1;
      st_reg.rx_stable  <= 1'b1;
      st_reg.hist       <= 2'h3;
      st_reg.rx_bit     <= 1'b1;
      // timer runs the shortest legal bit until the first reload
      st_reg.pos        <= `CBT_ONE_POS;
      st_reg.cur_sp     <= `CBT_SP_MIN + `CBT_ONE_POS;
      st_reg.cur_end    <= `CBT_LEN_MIN + `CBT_ONE_POS;
      st_reg.ratio      <= `CBT_ONE_RATIO + `CBT_ONE_RATIO;
      st_reg.bit_len    <= `CBT_LEN_MIN + `CBT_ONE_POS;
      st_reg.sample_pos <= `CBT_SP_MIN + `CBT_ONE_POS;
      st_reg.seg2       <= `CBT_LEN_MIN - `CBT_SP_MIN;
      st_reg.jump_width_field        <= 3'h1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  // mode bits come straight from the register bits, no decode
  assign rd_data_o               = st_reg.rd_data;
  assign time_quantum_o          = tq;
  assign bit_start_o             = st_reg.bit_start;
  assign sample_o                = st_reg.sample;
  assign rx_bit_o                = st_reg.rx_bit;
  assign prescale_ratio_o        = st_reg.ratio;
  assign bit_len_o               = st_reg.bit_len;
  assign sample_pos_o            = st_reg.sample_pos;
  assign phase_segment_two_o     = st_reg.seg2;
  assign jump_width_o            = st_reg.jump_width_field;
  assign cfg_bad_o               = st_reg.cfg_bad;
  assign fine_prescale_mode_o    = st_reg.high[`CBT_FINE_BIT];
  assign frame_start_clear_ctl_o = st_reg.high[`CBT_FRAME_START_CLEAR_CTL_BIT];
  assign triple_sampling_o       = st_reg.high[`CBT_TRIPLE_SAMPLING_BIT];
  assign listen_only_o           = st_reg.high[`CBT_LISTEN_BIT];

endmodule // cbt_bit_timing

`default_nettype wire

/* File: verification/cbt_bit_timing_monitor.sv */
// port assertions for the bit timing block
`timescale 1ns/1ns
`default_nettype none
`include "cbt_defines.svh"

module cbt_bit_timing_monitor
(
  // clock and reset
  input wire logic                    sys_clk_i,
  input wire logic                    rst_n_i,
  // inputs the outputs depend on
  input wire logic [5:0]              prescaler_field_i,
  input wire logic [1:0]              prescaler_upper_i,
  input wire logic                    can_rx_i,
  // watched outputs
  input wire logic                    time_quantum_o,
  input wire logic                    bit_start_o,
  input wire logic                    sample_o,
  input wire logic                    rx_bit_o,
  input wire logic [`CBT_RATIO_W-1:0] prescale_ratio_o,
  input wire logic [`CBT_POS_W-1:0]   bit_len_o,
  input wire logic [`CBT_POS_W-1:0]   sample_pos_o,
  input wire logic [`CBT_POS_W-1:0]   phase_segment_two_o,
  input wire logic [2:0]              jump_width_o,
  input wire logic                    cfg_bad_o,
  input wire logic                    fine_prescale_mode_o
);
  logic [9:0]  gap_reg;   // clocks since last quantum
  logic        seen_reg;  // quantum seen at a steady ratio
  logic [15:0] bs_reg;    // clocks since bit start
  logic [15:0] still_reg; // clocks since the pin moved
  logic [4:0]  qn_reg;    // quanta since bit start
  logic        ok_reg;    // timing steady over this bit

  // helper counters; a resync edge or a timing change voids the bit
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gap_reg   <= 10'h000;
      seen_reg  <= 1'b0;
      bs_reg    <= 16'h0000;
      still_reg <= 16'h0000;
      qn_reg    <= 5'h00;
      ok_reg    <= 1'b0;
    end
    else
    begin
      gap_reg   <= time_quantum_o ? 10'h001 : gap_reg + 10'h001;
      seen_reg  <= $changed(prescale_ratio_o) ? 1'b0 :
                   (seen_reg | time_quantum_o);
      bs_reg    <= bit_start_o ? 16'h0000 : bs_reg + {15'h0000, ~&bs_reg};
      still_reg <= $changed(can_rx_i) ? 16'h0000 :
                   still_reg + {15'h0000, ~&still_reg};
      qn_reg    <= bit_start_o ? {4'h0, time_quantum_o} :
                   qn_reg + {4'h0, time_quantum_o};
      if ($changed(bit_len_o) || $changed(sample_pos_o) ||
          $changed(prescale_ratio_o))
        ok_reg <= 1'b0;
      else if (bit_start_o)
        ok_reg <= ~cfg_bad_o;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // bit free of edges and timing changes
  sequence s_clean;
    ok_reg && !cfg_bad_o && ({1'b0, still_reg} > {1'b0, bs_reg} + 17'd8);
  endsequence

  a_ratio_coarse: assert property (
    $past(rst_n_i) && !$past(fine_prescale_mode_o) |-> prescale_ratio_o ==
    {2'b00, $past(prescaler_field_i), 1'b0} + 9'h002)
    else $error("coarse ratio wrong");
  a_ratio_fine: assert property (
    $past(rst_n_i) && $past(fine_prescale_mode_o) |-> prescale_ratio_o ==
    {1'b0, $past(prescaler_upper_i), $past(prescaler_field_i)} + 9'h001)
    else $error("fine ratio wrong");
  a_quantum_gap: assert property (
    time_quantum_o && seen_reg && $stable(prescale_ratio_o) |->
    gap_reg == {1'b0, prescale_ratio_o})
    else $error("quantum spacing wrong");
  a_seg_two: assert property (
    phase_segment_two_o == bit_len_o - sample_pos_o)
    else $error("phase segment two wrong");
  a_bad_flag: assert property (
    cfg_bad_o == !(bit_len_o inside {[5'd8:5'd25]} &&
    sample_pos_o inside {[5'd2:5'd17]}))
    else $error("prohibited code flag wrong");
  a_jump_range: assert property (
    jump_width_o inside {[3'd1:3'd4]})
    else $error("jump width out of range");
  a_sample_point: assert property (
    sample_o ##0 s_clean |-> qn_reg == sample_pos_o)
    else $error("sample point misplaced");
  a_bit_length: assert property (
    bit_start_o ##0 s_clean |-> qn_reg == bit_len_o)
    else $error("bit length wrong");
  a_rx_value: assert property (
    sample_o ##0 s_clean |-> rx_bit_o == can_rx_i)
    else $error("sampled bit wrong");
endmodule // cbt_bit_timing_monitor

bind cbt_bit_timing cbt_bit_timing_monitor i_mon (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .prescaler_field_i(prescaler_field_i),
  .prescaler_upper_i(prescaler_upper_i), .can_rx_i(can_rx_i),
  .time_quantum_o(time_quantum_o), .bit_start_o(bit_start_o),
  .sample_o(sample_o), .rx_bit_o(rx_bit_o),
  .prescale_ratio_o(prescale_ratio_o), .bit_len_o(bit_len_o),
  .sample_pos_o(sample_pos_o), .phase_segment_two_o(phase_segment_two_o),
  .jump_width_o(jump_width_o), .cfg_bad_o(cfg_bad_o),
  .fine_prescale_mode_o(fine_prescale_mode_o));

`default_nettype wire

/* File: verification/cbt_can_node.sv */
// far node model: drives the receive pin like a transceiver
`timescale 1ns/1ns
`default_nettype none

module cbt_can_node
(
  // clock
  input  wire logic        sys_clk_i,
  // bit period in clocks, zero keeps the bus idle
  input  wire logic [15:0] period_i,
  // level seen on the receive pin
  output logic             can_rx_o
);
  logic [15:0] cnt_reg = 16'h0000; // clocks into this bit
  logic        lvl_reg = 1'b1;     // recessive at rest

  assign can_rx_o = lvl_reg;

  // idle bus rests recessive; otherwise bits alternate so that
  // every second boundary is a recessive to dominant edge for the resync logic
  always @(posedge sys_clk_i)
  begin
    if (period_i == 16'h0000)
    begin
      cnt_reg <= 16'h0000;
      lvl_reg <= 1'b1;
    end
    else if (cnt_reg == period_i - 16'h0001)
    begin
      cnt_reg <= 16'h0000;
      lvl_reg <= ~lvl_reg;
    end
    else
      cnt_reg <= cnt_reg + 16'h0001;
  end
endmodule // cbt_can_node

`default_nettype wire

/* File: verification/tb.sv */
// testbench for the can bit timing block
`timescale 1ns/1ns
`default_nettype none
`include "cbt_defines.svh"

module tb;
  import cbt_pkg::*;

  logic        sys_clk_i = 1'b0;     // core clock
  logic        rst_n_i   = 1'b0;     // reset, low active
  logic [15:0] addr_i    = 16'h0000; // register address
  logic        wr_i      = 1'b0;     // write strobe
  logic        rd_i      = 1'b0;     // read strobe
  logic [7:0]  wr_data_i = 8'h00;    // write byte
  logic [5:0]  pre_f     = 6'h00;    // prescaler low bits
  logic [1:0]  pre_u     = 2'h0;     // prescaler upper bits
  logic [15:0] period    = 16'h0000; // far node bit period
  wire logic       can_rx, tq, bs, smp, rxb, bad, fine, frame_start_clear_ctl, triple_sampling, lsn;
  wire logic [7:0] rdata;
  wire logic [8:0] ratio;
  wire logic [4:0] blen, spos, seg2;
  wire logic [2:0] jump_width_field;
  wire logic [2:0] ev;               // events by index
  int error_cnt    = 0;
  int total_checks = 0;
  // fine bit, upper bits, field; expected ratio
  logic [8:0] pcode [5] = '{9'h0c0, 9'h0ff, 9'h1ff, 9'h100, 9'h145};
  int         pexp [5]  = '{2, 128, 256, 1, 70};
  // high, low, bit length, sample point
  logic [31:0] ttab [3] = '{32'h8087_0805, 32'h8218_1911, 32'h816f_100c};
  // prohibited high/low pairs
  logic [15:0] btab [4] = '{16'h8086, 16'h8099, 16'h8007, 16'h8238};

  assign ev = {smp, bs, tq};

  initial forever #2 sys_clk_i = ~sys_clk_i;

  cbt_bit_timing i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .wr_data_i(wr_data_i), .rd_data_o(rdata),
    .prescaler_field_i(pre_f), .prescaler_upper_i(pre_u),
    .can_rx_i(can_rx), .time_quantum_o(tq), .bit_start_o(bs),
    .sample_o(smp), .rx_bit_o(rxb), .prescale_ratio_o(ratio),
    .bit_len_o(blen), .sample_pos_o(spos), .phase_segment_two_o(seg2),
    .jump_width_o(jump_width_field), .cfg_bad_o(bad), .fine_prescale_mode_o(fine),
    .frame_start_clear_ctl_o(frame_start_clear_ctl), .triple_sampling_o(triple_sampling),
    .listen_only_o(lsn));

  cbt_can_node i_node (
    .sys_clk_i(sys_clk_i), .period_i(period), .can_rx_o(can_rx));

  // run summary and verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // four-state compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // byte write, one strobe cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    addr_i = a;
    wr_data_i = d;
    wr_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    wr_i = 1'b0;
  endtask

  // byte read; data is there one cycle after the strobe edge
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    #1;
    addr_i = a;
    rd_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    rd_i = 1'b0;
    chk(16'(rdata), 16'(exp));
  endtask

  // bounded wait for an event pulse, returns clocks waited
  task automatic wait_ev(input int which, output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    while (ev[which] !== 1'b1 && n < 8000);
    if (n >= 8000)
    begin
      error_cnt++;
      final_report();
    end
  endtask

  // main sequence
  initial
  begin
    int n;
    int i;
    repeat (6) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    rd(16'hffb9, 8'h18);
    rd(16'hffba, 8'h0e);
    rd(16'hffb8, 8'h00);
    chk(16'({blen, spos}), 16'h0331);
    chk(16'({seg2, jump_width_field}), 16'h0044);
    // each mode bit alone, every jump code
    for (i = 0; i < 4; i++)
    begin
      wr(16'hffba, (8'h80 >> i) | 8'(i << 2));
      rd(16'hffba, (8'h80 >> i) | 8'(i << 2));
      chk(16'({fine, frame_start_clear_ctl, triple_sampling, lsn}), 16'(4'h8 >> i));
      chk(16'(jump_width_field), 16'(i + 1));
    end
    // prescaler ends of both modes, quantum spacing
    for (i = 0; i < 5; i++)
    begin
      {pre_u, pre_f} = pcode[i][7:0];
      wr(16'hffba, {pcode[i][8], 7'h0e});
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk(16'(ratio), 16'(pexp[i]));
      wait_ev(0, n);
      wait_ev(0, n);
      chk(16'(n), 16'(pexp[i]));
    end
    // legal bit timings at ratio 1, both length limits
    {pre_u, pre_f} = 8'h00;
    for (i = 0; i < 3; i++)
    begin
      wr(16'hffba, ttab[i][31:24]);
      wr(16'hffb9, ttab[i][23:16]);
      repeat (3) wait_ev(1, n);
      wait_ev(1, n);
      chk(16'(n), 16'(ttab[i][15:8]));
      wait_ev(2, n);
      chk(16'(n), 16'(ttab[i][7:0]));
      chk(16'(seg2), 16'(ttab[i][15:8] - ttab[i][7:0]));
      chk(16'(bad), 16'h0000);
    end
    // prohibited codes are flagged, and the low byte reads back as written
    for (i = 0; i < 4; i++)
    begin
      wr(16'hffba, btab[i][15:8]);
      wr(16'hffb9, btab[i][7:0]);
      rd(16'hffb9, btab[i][7:0]);
      chk(16'(bad), 16'h0001);
    end
    // far node toggles every 400 clocks, single then triple sampling
    wr(16'hffb9, 8'h87);
    wr(16'hffba, 8'h80);
    period = 16'd400;
    repeat (600) @(posedge sys_clk_i);
    #1;
    chk(16'(rxb), 16'h0000);
    wr(16'hffba, 8'ha0);
    repeat (300) @(posedge sys_clk_i);
    #1;
    chk(16'(rxb), 16'h0001);
    // second reset in mid-run
    rst_n_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    rd(16'hffba, 8'h0e);
    final_report();
  end
endmodule // tb

`default_nettype wire
